/* File: pkg/sbcwd_consts.vh */
// Constants for the mode control, status and watchdog block.
// Assumes inclusion by bare name from the rtl files.
`ifndef SBCWD_CONSTS_VH
`define SBCWD_CONSTS_VH

// Register addresses
`define SBCWD_ADDR_WDCFG   7'h00
`define SBCWD_ADDR_MODE    7'h01
`define SBCWD_ADDR_STATUS  7'h03

// Field positions
`define SBCWD_WMC_MSB      7
`define SBCWD_WMC_LSB      5
`define SBCWD_NWP_MSB      3
`define SBCWD_NWP_LSB      0
`define SBCWD_OTW_BIT      6
`define SBCWD_NMS_BIT      5

// Operating mode codes
`define SBCWD_MC_SLEEP     3'h1
`define SBCWD_MC_STANDBY   3'h4
`define SBCWD_MC_NORMAL    3'h7

// Watchdog mode codes
`define SBCWD_WMC_AUTO     3'h1
`define SBCWD_WMC_TIMEOUT  3'h2
`define SBCWD_WMC_WINDOW   3'h4

// Watchdog period codes
`define SBCWD_NWP_8        4'h8
`define SBCWD_NWP_16       4'h1
`define SBCWD_NWP_32       4'h2
`define SBCWD_NWP_64       4'hB
`define SBCWD_NWP_128      4'h4
`define SBCWD_NWP_256      4'hD
`define SBCWD_NWP_1024     4'hE
`define SBCWD_NWP_4096     4'h7

// Reset values
`define SBCWD_NWP_RESET    4'h4
`define SBCWD_WMC_RESET    3'h2
`define SBCWD_MC_RESET     3'h4

// Reset cause codes
`define SBCWD_RSS_POWERON  5'h00
`define SBCWD_RSS_WD_SLEEP 5'h0C
`define SBCWD_RSS_EARLY    5'h0E
`define SBCWD_RSS_OVERFLOW 5'h0F
`define SBCWD_RSS_ILLEGAL  5'h10

// Timing: system clock period and watchdog time base, in ns
`define SBCWD_CLK_NS       10
`define SBCWD_MS_NS        1000000
`define SBCWD_MS_CYCLES    (`SBCWD_MS_NS / `SBCWD_CLK_NS)

`endif

/* File: rtl/sbcwd_period_timer.v */
// Watchdog period timer counting millisecond ticks.
// Assumes tick is a one-cycle enable on the same clock.
`include "sbcwd_consts.vh"

module sbcwd_period_timer #(
    parameter CW = 13
) (
    // Clock and reset
    input  wire          clk_sys,
    input  wire          reset_output_pin,
    // Control
    input  wire          run,
    input  wire          restart,
    input  wire          tick,
    input  wire [CW-1:0] periodMs,
    // Status
    output reg           firstHalfQ,
    output reg           overflowQ
);

    reg  [CW-1:0] countQ;
    wire [CW-1:0] lastCount;
    wire [CW-1:0] halfCount;

    assign lastCount = periodMs - {{(CW-1){1'b0}}, 1'b1};
    assign halfCount = {1'b0, periodMs[CW-1:1]};

    // Count ms ticks, restart on trigger, wrap on overflow
    always @(posedge clk_sys or negedge reset_output_pin) begin
        if (!reset_output_pin) begin
            countQ     <= {CW{1'b0}};
            firstHalfQ <= 1'b1;
            overflowQ  <= 1'b0;
        end else begin
            overflowQ <= 1'b0;
            if (!run || restart) begin
                countQ     <= {CW{1'b0}};
                firstHalfQ <= 1'b1;
            end else if (tick) begin
                if (countQ == lastCount) begin
                    countQ     <= {CW{1'b0}};
                    firstHalfQ <= 1'b1;
                    overflowQ  <= 1'b1;
                end else begin
                    countQ     <= countQ + {{(CW-1){1'b0}}, 1'b1};
                    firstHalfQ <= (countQ + {{(CW-1){1'b0}}, 1'b1})
                                  < halfCount;
                end
            end
        end
    end

endmodule // sbcwd_period_timer

/* File: rtl/sbcwd_mode_watchdog.v */
// Operating mode control, main status, reset cause and watchdog.
// Assumes a register port already decoded from serial frames,
// same clock; analog and strap inputs arrive asynchronously.
//
// Contract
// RULE1 - Mode codes: 001 Sleep, 100 Standby, 111 Normal
// RULE2 - Mode register sits at address 0x01
// RULE3 - Bit 6 reads overtemperature warning state
// RULE4 - Bit 5 set until Normal first entered
// RULE5 - Bits 4:0 hold reset cause, 00000 power-on
// RULE6 - Sleep wake-up causes use codes 00001-01101
// RULE7 - Early trigger 01110, overflow 01111, illegal 10000
// RULE8 - Pin, overload, undervoltage, sleep, fail-safe codes
// RULE9 - Watchdog mode codes 001, 010, 100
// RULE10 - Timeout mode: any trigger restarts timer
// RULE11 - Autonomous: off or Timeout by chip state
// RULE12 - Watchdog config changes only in Standby
// RULE13 - Window acts as Timeout outside Normal
// RULE14 - Mode change in Normal forces reset, 10000
// RULE15 - Period field encodes eight periods 8-4096 ms
// RULE16 - Period defaults to 128 ms
// RULE17 - Valid watchdog register write is a trigger
// RULE18 - New mode and period apply immediately
// RULE19 - Mode defaults Timeout, Autonomous with development
// RULE20 - Window: early trigger or overflow resets
// RULE21 - Invalid mode or period code discarded, flagged
// RULE22 - Development plus Autonomous keeps watchdog off
// RULE23 - Reserved bits read zero, writes ignored
`include "sbcwd_consts.vh"

module sbcwd_mode_watchdog #(
    parameter MS_CYCLES = `SBCWD_MS_CYCLES
) (
    // Clock and reset
    input  wire       clk_sys,
    input  wire       reset_output_pin,
    // Register port
    input  wire       regWrite,
    input  wire       regRead,
    input  wire [6:0] regAddr,
    input  wire [7:0] regWdata,
    output reg  [7:0] regRdataQ,
    output reg        regRvalidQ,
    // Asynchronous inputs
    input  wire       overtempWarn,
    input  wire       softwareDevelopmentEnable,
    // Chip context, same clock
    input  wire       hostIntPending,
    input  wire       extResetValid,
    input  wire [4:0] extResetCause,
    // Outputs
    output reg  [2:0] operatingModeQ,
    output reg        chipResetQ,
    output reg        spiFailQ,
    output reg        watchdogActiveQ,
    output reg        windowActiveQ
);

    localparam CW = 13;

    // Watchdog behaviour states, one-hot
    localparam WD_OFF     = 3'b001;
    localparam WD_TIMEOUT = 3'b010;
    localparam WD_WINDOW  = 3'b100;

    reg  [2:0]    wdModeQ;
    reg  [3:0]    wdPeriodQ;
    reg           notYetNormalQ;
    reg  [4:0]    resetCauseQ;
    reg           otwMetaQ;
    reg           otwSyncQ;
    reg           sdmMetaQ;
    reg           sdmSyncQ;
    reg           sdmQ;
    reg           sdmCapturedQ;
    reg  [1:0]    sdmWaitQ;
    reg  [16:0]   divCountQ;
    reg           msTickQ;
    reg           triggerQ;
    reg  [2:0]    wdState;
    reg  [CW-1:0] periodMs;
    reg           modeValid;
    reg           periodValid;
    wire          firstHalf;
    wire          overflow;
    wire          wdWrite;
    wire          modeWrite;
    wire [2:0]    newWdMode;
    wire [3:0]    newPeriod;
    wire [2:0]    newOpMode;
    wire          cfgValid;
    wire          inNormal;
    wire          inStandby;
    wire          inSleep;
    wire          earlyTrigger;
    wire          illegalChange;
    wire          wdReset;

    assign wdWrite   = regWrite && (regAddr == `SBCWD_ADDR_WDCFG);
    assign modeWrite = regWrite && (regAddr == `SBCWD_ADDR_MODE); // RULE2
    assign newWdMode = regWdata[`SBCWD_WMC_MSB:`SBCWD_WMC_LSB];
    assign newPeriod = regWdata[`SBCWD_NWP_MSB:`SBCWD_NWP_LSB];
    assign newOpMode = regWdata[2:0];
    assign inNormal  = (operatingModeQ == `SBCWD_MC_NORMAL);
    assign inStandby = (operatingModeQ == `SBCWD_MC_STANDBY);
    assign inSleep   = (operatingModeQ == `SBCWD_MC_SLEEP);

    // Decode the written watchdog mode code
    always @* begin
        case (newWdMode)
            `SBCWD_WMC_AUTO:    modeValid = 1'b1; // RULE9
            `SBCWD_WMC_TIMEOUT: modeValid = 1'b1;
            `SBCWD_WMC_WINDOW:  modeValid = 1'b1;
            default:            modeValid = 1'b0; // RULE21
        endcase
    end

    // Decode the written period code
    always @* begin
        case (newPeriod)
            `SBCWD_NWP_8, `SBCWD_NWP_16, `SBCWD_NWP_32,
            `SBCWD_NWP_64, `SBCWD_NWP_128, `SBCWD_NWP_256,
            `SBCWD_NWP_1024, `SBCWD_NWP_4096: periodValid = 1'b1;
            default:                           periodValid = 1'b0;
        endcase
    end

    assign cfgValid = modeValid && periodValid; // RULE21

    // Stored period code to length in ms
    always @* begin
        case (wdPeriodQ)
            `SBCWD_NWP_8:    periodMs = 13'd8; // RULE15
            `SBCWD_NWP_16:   periodMs = 13'd16;
            `SBCWD_NWP_32:   periodMs = 13'd32;
            `SBCWD_NWP_64:   periodMs = 13'd64;
            `SBCWD_NWP_256:  periodMs = 13'd256;
            `SBCWD_NWP_1024: periodMs = 13'd1024;
            `SBCWD_NWP_4096: periodMs = 13'd4096;
            default:         periodMs = 13'd128;
        endcase
    end

    // Effective watchdog behaviour from mode and chip state
    always @* begin
        wdState = WD_OFF;
        if (inNormal || inStandby || inSleep) begin
            case (wdModeQ)
                `SBCWD_WMC_WINDOW: begin
                    if (inNormal) begin
                        wdState = WD_WINDOW; // RULE13
                    end else begin
                        wdState = WD_TIMEOUT; // RULE13
                    end
                end
                `SBCWD_WMC_TIMEOUT: wdState = WD_TIMEOUT; // RULE10
                `SBCWD_WMC_AUTO: begin
                    if (sdmQ) begin
                        wdState = WD_OFF; // RULE22
                    end else if (inNormal ||
                                 (inStandby && hostIntPending)) begin
                        wdState = WD_TIMEOUT; // RULE11
                    end else begin
                        wdState = WD_OFF; // RULE11
                    end
                end
                default: wdState = WD_OFF;
            endcase
        end
    end

    // Two-flop synchronisers for analog flag and strap
    always @(posedge clk_sys or negedge reset_output_pin) begin
        if (!reset_output_pin) begin
            otwMetaQ <= 1'b0;
            otwSyncQ <= 1'b0;
            sdmMetaQ <= 1'b0;
            sdmSyncQ <= 1'b0;
            sdmWaitQ <= 2'h0;
        end else begin
            otwMetaQ <= overtempWarn;
            otwSyncQ <= otwMetaQ;
            sdmMetaQ <= softwareDevelopmentEnable;
            sdmSyncQ <= sdmMetaQ;
            if (sdmWaitQ != 2'h2) begin
                sdmWaitQ <= sdmWaitQ + 2'h1; // Strap settle count
            end
        end
    end

    // Millisecond time base from the system clock
    always @(posedge clk_sys or negedge reset_output_pin) begin
        if (!reset_output_pin) begin
            divCountQ <= 17'h00000;
            msTickQ   <= 1'b0;
        end else if (divCountQ == MS_CYCLES[16:0] - 17'h00001) begin
            divCountQ <= 17'h00000;
            msTickQ   <= 1'b1;
        end else begin
            divCountQ <= divCountQ + 17'h00001;
            msTickQ   <= 1'b0;
        end
    end

    assign earlyTrigger  = wdWrite && cfgValid && (wdState == WD_WINDOW)
                           && firstHalf; // RULE20
    assign illegalChange = wdWrite && cfgValid && inNormal
                           && (newWdMode != wdModeQ); // RULE14
    assign wdReset       = overflow && (wdState != WD_OFF);

    // Period timer; restarted by triggers and chip resets, held clear while off
    sbcwd_period_timer #(
        .CW         (CW)
    ) u_timer (
        .clk_sys    (clk_sys),
        .reset_output_pin       (reset_output_pin),
        .run        (wdState != WD_OFF),
        .restart    (triggerQ || chipResetQ),
        .tick       (msTickQ),
        .periodMs   (periodMs),
        .firstHalfQ (firstHalf),
        .overflowQ  (overflow)
    );

    // Watchdog configuration register and triggers
    always @(posedge clk_sys or negedge reset_output_pin) begin
        if (!reset_output_pin) begin
            wdModeQ      <= `SBCWD_WMC_RESET; // RULE19
            wdPeriodQ    <= `SBCWD_NWP_RESET; // RULE16
            sdmQ         <= 1'b0;
            sdmCapturedQ <= 1'b0;
            triggerQ     <= 1'b0;
            spiFailQ     <= 1'b0;
        end else begin
            triggerQ <= 1'b0;
            spiFailQ <= 1'b0;
            if (!sdmCapturedQ) begin
                // Strap taken once, after synchroniser settles
                if (sdmWaitQ == 2'h2) begin
                    sdmCapturedQ <= 1'b1;
                    sdmQ         <= sdmSyncQ;
                    if (sdmSyncQ) begin
                        wdModeQ <= `SBCWD_WMC_AUTO; // RULE19
                    end
                end
            end else if (chipResetQ) begin
                wdPeriodQ <= `SBCWD_NWP_RESET; // RULE16
                if (sdmQ) begin
                    wdModeQ <= `SBCWD_WMC_AUTO; // RULE19
                end else begin
                    wdModeQ <= `SBCWD_WMC_RESET; // RULE19
                end
            end else if (wdWrite) begin
                if (!cfgValid) begin
                    spiFailQ <= 1'b1; // RULE21
                end else begin
                    triggerQ <= 1'b1; // RULE17
                    if (inStandby) begin
                        wdModeQ   <= newWdMode; // RULE12 RULE18
                        wdPeriodQ <= newPeriod; // RULE18
                    end
                end
            end
        end
    end

    // Operating mode, not-yet-normal flag, reset cause, reset pulse
    always @(posedge clk_sys or negedge reset_output_pin) begin
        if (!reset_output_pin) begin
            operatingModeQ <= `SBCWD_MC_RESET;
            notYetNormalQ  <= 1'b1; // RULE4
            resetCauseQ    <= `SBCWD_RSS_POWERON; // RULE5
            chipResetQ     <= 1'b0;
        end else begin
            chipResetQ <= 1'b0;
            if (illegalChange) begin
                resetCauseQ    <= `SBCWD_RSS_ILLEGAL; // RULE7 RULE14
                chipResetQ     <= 1'b1;
                operatingModeQ <= `SBCWD_MC_STANDBY;
            end else if (earlyTrigger) begin
                resetCauseQ    <= `SBCWD_RSS_EARLY; // RULE7 RULE20
                chipResetQ     <= 1'b1;
                operatingModeQ <= `SBCWD_MC_STANDBY;
            end else if (wdReset) begin
                if (inSleep) begin
                    resetCauseQ <= `SBCWD_RSS_WD_SLEEP; // RULE6
                end else begin
                    resetCauseQ <= `SBCWD_RSS_OVERFLOW; // RULE7 RULE20
                end
                chipResetQ     <= 1'b1;
                operatingModeQ <= `SBCWD_MC_STANDBY;
            end else if (extResetValid) begin
                resetCauseQ    <= extResetCause; // RULE6 RULE8
                chipResetQ     <= 1'b1;
                operatingModeQ <= `SBCWD_MC_STANDBY;
            end else if (modeWrite) begin
                case (newOpMode)
                    `SBCWD_MC_SLEEP, `SBCWD_MC_STANDBY: begin
                        operatingModeQ <= newOpMode; // RULE1
                    end
                    `SBCWD_MC_NORMAL: begin
                        operatingModeQ <= newOpMode; // RULE1
                        notYetNormalQ  <= 1'b0; // RULE4
                    end
                    default: operatingModeQ <= operatingModeQ;
                endcase
            end
        end
    end

    // Register read data; reserved bits zero
    always @(posedge clk_sys or negedge reset_output_pin) begin
        if (!reset_output_pin) begin
            regRdataQ  <= 8'h00;
            regRvalidQ <= 1'b0;
        end else begin
            regRvalidQ <= regRead;
            if (!regRead) begin
                regRdataQ <= regRdataQ;
            end else if (regAddr == `SBCWD_ADDR_WDCFG) begin
                regRdataQ <= {wdModeQ, 1'b0, wdPeriodQ}; // RULE23
            end else if (regAddr == `SBCWD_ADDR_MODE) begin
                regRdataQ <= {5'h00, operatingModeQ}; // RULE2 RULE23
            end else if (regAddr == `SBCWD_ADDR_STATUS) begin
                regRdataQ <= {1'b0, otwSyncQ, notYetNormalQ,
                              resetCauseQ}; // RULE3 RULE4 RULE5
            end else begin
                regRdataQ <= 8'h00;
            end
        end
    end

    // Watchdog status outputs
    always @(posedge clk_sys or negedge reset_output_pin) begin
        if (!reset_output_pin) begin
            watchdogActiveQ <= 1'b0;
            windowActiveQ   <= 1'b0;
        end else begin
            watchdogActiveQ <= (wdState != WD_OFF);
            windowActiveQ   <= (wdState == WD_WINDOW);
        end
    end

endmodule // sbcwd_mode_watchdog

/* File: tb/sbcwd_wd_assertions.sv */
// Port assertions for the mode control and watchdog block.
// Assumes a bind to sbcwd_mode_watchdog, one clock domain.
module sbcwd_wd_checker #(
    parameter MS_CYCLES = 10
) (
    // Clock and reset
    input wire       clk_sys,
    input wire       reset_output_pin,
    // Register port
    input wire       regWrite,
    input wire       regRead,
    input wire [6:0] regAddr,
    input wire [7:0] regWdata,
    input wire       regRvalidQ,
    // Context and outputs
    input wire       extResetValid,
    input wire [2:0] operatingModeQ,
    input wire       chipResetQ,
    input wire       spiFailQ,
    input wire       watchdogActiveQ,
    input wire       windowActiveQ
);
    timeunit 1ns;
    timeprecision 1ps;
    // Decode of configuration and mode writes
    wire badCfg = regWrite && regAddr == 7'h00 &&
        (!(regWdata[7:5] inside {3'h1, 3'h2, 3'h4}) ||
         !(regWdata[3:0] inside {4'h8, 4'h1, 4'h2, 4'hB, 4'h4, 4'hD,
                                 4'hE, 4'h7}));
    wire modeWr = regWrite && regAddr == 7'h01 && !extResetValid;
    wire legalMc = regWdata[2:0] inside {3'h1, 3'h4, 3'h7};
    wire [2:0] mcReq = regWdata[2:0];
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_output_pin);
    a_read_answer: assert property (regRead |=> regRvalidQ)
        else $error("read without answer");
    a_answer_cause: assert property (regRvalidQ |-> $past(regRead))
        else $error("answer without read");
    a_fail_flag: assert property (badCfg |=> spiFailQ)
        else $error("bad write not flagged");
    a_fail_cause: assert property (spiFailQ |-> $past(badCfg))
        else $error("flag without bad write");
    a_reset_standby: assert property (chipResetQ |-> operatingModeQ == 3'h4)
        else $error("reset not to standby");
    a_reset_single: assert property (chipResetQ |=> !chipResetQ)
        else $error("reset pulse too long");
    a_window_normal: assert property (windowActiveQ |->
        $past(operatingModeQ) == 3'h7 && watchdogActiveQ)
        else $error("window outside normal");
    a_mode_legal: assert property (operatingModeQ inside {3'h1, 3'h4, 3'h7})
        else $error("illegal mode code");
    a_mode_write: assert property (modeWr && legalMc &&
        operatingModeQ != 3'h1 |=> operatingModeQ == $past(mcReq) || chipResetQ)
        else $error("mode write not applied");
    a_mode_ignore: assert property (modeWr && !legalMc |=>
        $stable(operatingModeQ) || chipResetQ)
        else $error("bad mode code applied");
endmodule // sbcwd_wd_checker

bind sbcwd_mode_watchdog sbcwd_wd_checker #(.MS_CYCLES(MS_CYCLES)) i_chk (
    .clk_sys(clk_sys), .reset_output_pin(reset_output_pin), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
    .regRvalidQ(regRvalidQ), .extResetValid(extResetValid),
    .operatingModeQ(operatingModeQ), .chipResetQ(chipResetQ),
    .spiFailQ(spiFailQ), .watchdogActiveQ(watchdogActiveQ),
    .windowActiveQ(windowActiveQ));

/* File: tb/sbcwd_host_model.sv */
// Host model driving the decoded register port.
// Assumes the bench calls access; strobes change at falling edges.
module sbcwd_host_model (
    // Clock
    input  wire        clk_sys,
    // Register port
    output logic       regWrite,
    output logic       regRead,
    output logic [6:0] regAddr,
    output logic [7:0] regWdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle port at time zero
    initial begin
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 7'h7F;
        regWdata = 8'hFF;
    end
    // One strobe cycle, then address and data scrambled
    task automatic access(input logic w, input logic [6:0] a,
                          input logic [7:0] d);
        @(negedge clk_sys);
        regWrite = w;
        regRead = !w;
        regAddr = a;
        regWdata = d;
        @(negedge clk_sys);
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = ~a;
        regWdata = ~d;
    endtask
endmodule // sbcwd_host_model

/* File: tb/tb.sv */
// Self-checking bench for the mode control and watchdog block.
// Assumes the host model drives the register port; 100 MHz clock.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MSC = 10;
    logic clk_sys = 1'b0;
    logic reset_output_pin = 1'b0;
    logic regWrite, regRead, regRvalidQ, chipResetQ, spiFailQ;
    logic watchdogActiveQ, windowActiveQ, overtempWarn, hostIntPending;
    logic softwareDevelopmentEnable, extResetValid, not_yet_normal_flag = 1'b1;
    logic [6:0] regAddr;
    logic [7:0] regWdata, regRdataQ;
    logic [2:0] operatingModeQ;
    logic [4:0] extResetCause;
    logic [7:0] expQ[$];
    logic [31:0] lfsr = 32'h59A11834;
    logic [3:0] pcs [6] = '{4'h1, 4'h2, 4'hB, 4'hD, 4'hE, 4'h7};
    int nFail = 0, checks = 0, nRst = 0, rst0 = 0, cyc = 0;

    always #5 clk_sys = ~clk_sys;

    sbcwd_mode_watchdog #(.MS_CYCLES(MSC)) i_sbcwd_mode_watchdog (
        .clk_sys(clk_sys), .reset_output_pin(reset_output_pin), .regWrite(regWrite),
        .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
        .regRdataQ(regRdataQ), .regRvalidQ(regRvalidQ),
        .overtempWarn(overtempWarn),
        .softwareDevelopmentEnable(softwareDevelopmentEnable),
        .hostIntPending(hostIntPending), .extResetValid(extResetValid),
        .extResetCause(extResetCause), .operatingModeQ(operatingModeQ),
        .chipResetQ(chipResetQ), .spiFailQ(spiFailQ),
        .watchdogActiveQ(watchdogActiveQ), .windowActiveQ(windowActiveQ));
    sbcwd_host_model i_sbcwd_host_model (
        .clk_sys(clk_sys), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWdata(regWdata));

    function automatic logic [31:0] nextRnd(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] stat(input logic [4:0] c);
        return {1'b0, overtempWarn, not_yet_normal_flag, c};
    endfunction
    task automatic fail(input string m);
        nFail++;
        $display("[FAIL] %0t %s", $time, m);
    endtask
    task automatic check(input logic c, input string m);
        checks++;
        if (c !== 1'b1) fail(m);
    endtask
    task automatic end_sim();
        $display("checks %0d failures %0d", checks, nFail);
        if (nFail == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        i_sbcwd_host_model.access(1'b1, a, d);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        expQ.push_back(e);
        i_sbcwd_host_model.access(1'b0, a, e);
    endtask
    // Bounded wait for a reset pulse, then the cause is read back
    task automatic waitRst(input logic [4:0] c, input int lim);
        repeat (lim) if (nRst == rst0) @(posedge clk_sys);
        check(nRst != rst0, "no reset");
        rd(7'h03, stat(c));
    endtask

    // Read answers against oldest note, reset count, timeout
    always @(negedge clk_sys) begin
        cyc++;
        if (chipResetQ === 1'b1) nRst++;
        if (regRvalidQ === 1'b1) begin
            checks++;
            if (expQ.size() == 0 || regRdataQ !== expQ[0]) fail("read data");
            if (expQ.size() != 0) void'(expQ.pop_front());
        end
        if (cyc == 5000) begin
            fail("timeout");
            end_sim();
        end
    end

    // Main sequence
    initial begin
        lfsr = nextRnd(lfsr);
        overtempWarn = lfsr[0];
        hostIntPending = lfsr[1];
        softwareDevelopmentEnable = 1'b0;
        extResetValid = 1'b0;
        extResetCause = 5'h00;
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys) reset_output_pin = 1'b1;
        repeat (5) @(posedge clk_sys);
        rd(7'h00, 8'h44);
        rd(7'h01, 8'h04);
        rd(7'h03, stat(5'h00));
        rd(7'h02, 8'h00);
        wr(7'h00, 8'h64);
        check(spiFailQ === 1'b1, "no fail flag");
        wr(7'h00, 8'h49);
        rd(7'h00, 8'h44);
        // Every remaining period code except 8 (8 ms) is stored and read back
        foreach (pcs[i]) begin
            wr(7'h00, {4'h4, pcs[i]});
            rd(7'h00, {4'h4, pcs[i]});
        end
        rst0 = nRst;
        wr(7'h00, 8'h58);
        repeat (3) begin
            repeat (60) @(posedge clk_sys);
            wr(7'h00, 8'h48);
        end
        check(nRst == rst0, "early overflow");
        rd(7'h00, 8'h48);
        waitRst(5'h0F, 120);
        wr(7'h01, 8'h02);
        rd(7'h01, 8'h04);
        wr(7'h01, 8'hF7);
        not_yet_normal_flag = 1'b0;
        rd(7'h01, 8'h07);
        rd(7'h03, stat(5'h0F));
        wr(7'h00, 8'h48);
        rd(7'h00, 8'h44);
        rst0 = nRst;
        wr(7'h00, 8'h84);
        waitRst(5'h10, 4);
        rd(7'h00, 8'h44);
        // Window: early trigger, then a second-half trigger
        for (int k = 0; k < 2; k++) begin
            wr(7'h00, 8'h88);
            check(windowActiveQ === 1'b0, "window early");
            wr(7'h01, 8'h07);
            rst0 = nRst;
            repeat (k ? 55 : 1) @(negedge clk_sys);
            check(windowActiveQ === 1'b1, "window off");
            wr(7'h00, 8'h88);
            waitRst(k ? 5'h0F : 5'h0E, 100);
        end
        wr(7'h00, 8'h48);
        rst0 = nRst;
        wr(7'h01, 8'h01);
        waitRst(5'h0C, 100);
        hostIntPending = 1'b0;
        wr(7'h00, 8'h28);
        rst0 = nRst;
        repeat (100) @(posedge clk_sys);
        check(nRst == rst0, "autonomous ran");
        @(negedge clk_sys) hostIntPending = 1'b1;
        waitRst(5'h0F, 100);
        // Causes reported by the rest of the chip
        for (int k = 1; k < 22; k++) begin
            if (k < 14 || k > 16) begin
                @(negedge clk_sys);
                extResetValid = 1'b1;
                extResetCause = k[4:0];
                @(negedge clk_sys);
                extResetValid = 1'b0;
                extResetCause = ~k[4:0];
                rd(7'h03, stat(k[4:0]));
            end
        end
        // Second reset with the development strap set
        softwareDevelopmentEnable = 1'b1;
        reset_output_pin = 1'b0;
        repeat (2) @(negedge clk_sys);
        reset_output_pin = 1'b1;
        not_yet_normal_flag = 1'b1;
        repeat (5) @(posedge clk_sys);
        rd(7'h00, 8'h24);
        rd(7'h03, stat(5'h00));
        wr(7'h01, 8'h07);
        repeat (100) @(posedge clk_sys);
        check(watchdogActiveQ === 1'b0, "watchdog on");
        check(expQ.size() == 0, "missing answers");
        end_sim();
    end
endmodule // tb
